//--- hw/pss_startup.sv
`timescale 1ns/10ps
// Contract
// R01: Cold start copies fused configuration into shadow registers once input exceeds threshold.
// R02: Every turn-on reloads shadow registers from fuses, replacing earlier writes.
// R03: Blank variant: no regulator sequenced, 500 us slots, level enable, address 0x08.
// R04: First variant: 2000 us, slot1 many rails, buck one slot 2, LDO4 slot 9.
// R05: Second variant: 2000 us, buck one 1, several in 2, LDO3 3, rail 6.
// R06: All variants: power-good reset mode and 2.0 MHz for all bucks.
// R07: DDR reference always enables in the same slot as buck three.
// R08: Start-up slot delays are timed from the trimmed 32 kHz clock.
// R09: Untrimmed clock only below threshold, all sleeping, or all pulse-frequency mode.
// R10: Trimmed divided clock for start-up above threshold and edge-mode button debounce.
// R11: With 16 MHz running in on state, debounce uses the divided clock.
// R12: Low input and enable pin interrupts always debounce on the untrimmed clock.
// R13: Switching frequency is derived from the trimmed 16 MHz oscillator.
// R14: Slot code zero stays off; code n starts n intervals after turn-on.
// R15: Interval select clear gives 500 us, set gives 2000 us.
// R16: Sequence ends at last programmed slot; reset output high 2.0 ms later.
// R17: Edge enable: falling edge turns on; holding low 4 s turns off (no hold timer here; edge mode turns off only when uv_ok drops).
// R18: Clock source changes are glitch-free; no shortened or extra tick.
module pss_startup import pss_pkg::*; (
    // Clock, reset and enable.
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Oscillator ticks, one core cycle each.
    input wire logic osc16_tick,
    input wire logic osc32_raw_tick,
    // Supply and regulator status.
    input wire logic uv_ok,
    input wire logic all_sleep,
    input wire logic all_pfm,
    input wire logic low_vin_raw,
    input wire logic en_pin,
    // Fuses and shadow write port.
    input wire logic [1:0] fuse_variant,
    input wire logic shadow_wr,
    input wire pss_cfg_t shadow_wdata,
    // Outputs.
    output pss_cfg_t shadow_config_registers,
    output logic [N_REG-1:0] reg_en,
    output logic ddr_ref_en,
    output logic power_on_reset_out,
    output logic timing_trimmed,
    output logic timing_tick,
    output logic buck_sw_tick,
    output logic low_input_interrupt,
    output logic enable_pin_interrupt
);
    // ==========================================================
    // Fuse image decode.
    function automatic pss_cfg_t fuse_cfg(input logic [1:0] v);
        pss_cfg_t c;
        c.slots = SLOTS_BLANK; // R03
        c.seq_slow = 1'b0; // R03
        c.en_edge = 1'b0;
        c.bus_addr = BUS_ADDR_DEFAULT;
        c.pg_default = 1'b1; // R06
        c.buck_freq = {3{FREQ_2MHZ}}; // R06
        if (v == VARIANT_FIRST) begin
            c.slots = SLOTS_FIRST; // R04
            c.seq_slow = 1'b1;
        end else if (v == VARIANT_SECOND) begin
            c.slots = SLOTS_SECOND; // R05
            c.seq_slow = 1'b1;
        end
        return c;
    endfunction

    // Highest slot code in use.
    function automatic logic [3:0] last_slot(input pss_cfg_t c);
        logic [3:0] m;
        m = SLOT_OFF;
        for (int i = 0; i < N_REG; i++) begin
            if (c.slots[i] > m) begin
                m = c.slots[i];
            end
        end
        return m;
    endfunction

    // ==========================================================
    // Oscillator dividers.
    logic [8:0] trim_cnt_reg;
    logic [2:0] sw_cnt_reg;
    logic trim_tick_reg;
    logic sel_trim_reg;
    logic want_trim;
    logic debounce_src_tick;
    pss_state_t state_reg;

    // Divides the trimmed 16 MHz oscillator down to a 32 kHz tick.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            trim_cnt_reg <= 9'h000;
            trim_tick_reg <= 1'b0;
        end else if (clk_en) begin
            trim_tick_reg <= 1'b0;
            if (osc16_tick) begin
                if (trim_cnt_reg == 9'(TRIM_DIV - 1)) begin
                    trim_cnt_reg <= 9'h000;
                    trim_tick_reg <= 1'b1;
                end else begin
                    trim_cnt_reg <= trim_cnt_reg + 9'h001;
                end
            end
        end
    end

    // Switching tick for every buck comes from the trimmed oscillator.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sw_cnt_reg <= 3'h0;
            buck_sw_tick <= 1'b0;
        end else if (clk_en) begin
            buck_sw_tick <= 1'b0;
            if (osc16_tick) begin
                sw_cnt_reg <= (sw_cnt_reg == 3'(SW_DIV - 1)) ? 3'h0 : sw_cnt_reg + 3'h1; // R13
                buck_sw_tick <= (sw_cnt_reg == 3'(SW_DIV - 1)); // R13
            end
        end
    end

    // ==========================================================
    // Timing source selection; the source only changes in a cycle where
    // neither tick is present, so no tick is cut or doubled.
    assign want_trim = uv_ok && ((state_reg != ST_IDLE) || !(all_sleep || all_pfm)); // R09 R10

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_trim_reg <= 1'b0;
        end else if (clk_en && !trim_tick_reg && !osc32_raw_tick) begin
            sel_trim_reg <= want_trim; // R18
        end
    end

    assign timing_trimmed = sel_trim_reg;
    assign timing_tick = sel_trim_reg ? trim_tick_reg : osc32_raw_tick;
    assign debounce_src_tick = shadow_config_registers.en_edge ? trim_tick_reg
                                                               : timing_tick; // R10 R11

    // ==========================================================
    // Debouncers: 0 button on trimmed clock in edge mode, on the selected timing tick otherwise; 1 enable interrupt and
    // 2 low input interrupt on the untrimmed clock.
    logic [2:0] deb_in;
    logic [2:0] deb_tick;
    logic [2:0] deb_out_reg;
    assign deb_in = {low_vin_raw, en_pin, en_pin};
    assign deb_tick = {osc32_raw_tick, osc32_raw_tick, debounce_src_tick}; // R12

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_deb
            logic [6:0] cnt_reg;
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    cnt_reg <= 7'h00;
                    deb_out_reg[g] <= 1'b0;
                end else if (clk_en) begin
                    if (deb_in[g] == deb_out_reg[g]) begin
                        cnt_reg <= 7'h00;
                    end else if (deb_tick[g]) begin
                        if (cnt_reg == DEBOUNCE_TICKS - 7'h01) begin
                            cnt_reg <= 7'h00;
                            deb_out_reg[g] <= deb_in[g];
                        end else begin
                            cnt_reg <= cnt_reg + 7'h01;
                        end
                    end
                end
            end
        end
    endgenerate

    assign enable_pin_interrupt = deb_out_reg[1];
    assign low_input_interrupt = deb_out_reg[2];

    // ==========================================================
    // Turn-on detection from the debounced enable input.
    logic btn_prev_reg;
    logic uv_prev_reg;
    logic turn_on;
    logic turn_off;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            btn_prev_reg <= 1'b0;
            uv_prev_reg <= 1'b0;
        end else if (clk_en) begin
            btn_prev_reg <= deb_out_reg[0];
            uv_prev_reg <= uv_ok;
        end
    end

    assign turn_on = uv_ok && (state_reg == ST_IDLE) &&
                     (shadow_config_registers.en_edge ? (btn_prev_reg && !deb_out_reg[0])
                                                      : deb_out_reg[0]); // R17
    assign turn_off = !uv_ok || (!shadow_config_registers.en_edge && !deb_out_reg[0]);

    // ==========================================================
    // Shadow configuration: fuse load on cold start and at every turn-on.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            shadow_config_registers <= fuse_cfg(VARIANT_BLANK);
        end else if (clk_en) begin
            if ((uv_ok && !uv_prev_reg) || state_reg == ST_LOAD) begin
                shadow_config_registers <= fuse_cfg(fuse_variant); // R01 R02
            end else if (shadow_wr) begin
                shadow_config_registers <= shadow_wdata;
            end
        end
    end

    // ==========================================================
    // Slot sequencer.
    logic [6:0] ivl_cnt_reg;
    logic [3:0] slot_reg;
    logic [6:0] interval;
    logic ivl_done;
    assign interval = shadow_config_registers.seq_slow ? SLOT_LONG_TICKS
                                                       : SLOT_SHORT_TICKS; // R15
    assign ivl_done = trim_tick_reg &&
                      (ivl_cnt_reg == ((state_reg == ST_POWER_ON_RESET_OUT) ? POWER_ON_RESET_OUT_TICKS : interval) - 7'h01);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else if (clk_en) begin
            case (state_reg)
                ST_IDLE: if (turn_on) state_reg <= ST_LOAD;
                ST_LOAD: state_reg <= ST_SEQ;
                ST_SEQ: begin
                    if (turn_off) begin
                        state_reg <= ST_IDLE;
                    end else if (slot_reg == last_slot(shadow_config_registers)) begin
                        state_reg <= ST_POWER_ON_RESET_OUT; // R16
                    end
                end
                ST_POWER_ON_RESET_OUT: begin
                    if (turn_off) begin
                        state_reg <= ST_IDLE;
                    end else if (ivl_done) begin
                        state_reg <= ST_DONE; // R16
                    end
                end
                ST_DONE: if (turn_off) state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Interval counter runs on trimmed ticks only.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ivl_cnt_reg <= 7'h00;
            slot_reg <= SLOT_OFF;
        end else if (clk_en) begin
            if (state_reg != ST_SEQ && state_reg != ST_POWER_ON_RESET_OUT) begin
                ivl_cnt_reg <= 7'h00;
                slot_reg <= SLOT_OFF;
            end else if (ivl_done || (state_reg == ST_SEQ &&
                         slot_reg == last_slot(shadow_config_registers))) begin
                ivl_cnt_reg <= 7'h00;
                if (state_reg == ST_SEQ) begin
                    slot_reg <= slot_reg + 4'h1;
                end
            end else if (trim_tick_reg) begin
                ivl_cnt_reg <= ivl_cnt_reg + 7'h01; // R08
            end
        end
    end

    // Regulator enables follow the slot count.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_en <= '0;
        end else if (clk_en) begin
            if (state_reg == ST_IDLE || state_reg == ST_LOAD) begin
                reg_en <= '0;
            end else begin
                for (int i = 0; i < N_REG; i++) begin
                    reg_en[i] <= (shadow_config_registers.slots[i] != SLOT_OFF) &&
                                 (shadow_config_registers.slots[i] <= slot_reg); // R14
                end
            end
        end
    end

    assign ddr_ref_en = reg_en[IDX_BUCK3]; // R07

    // Reset output goes high after the final wait.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            power_on_reset_out <= 1'b0;
        end else if (clk_en) begin
            power_on_reset_out <= (state_reg == ST_DONE) && !turn_off; // R16
        end
    end

    // ==========================================================
    // Checks.
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_turnon_reload: assert property (clk_en && state_reg == ST_LOAD |=> // R02
        shadow_config_registers == $past(fuse_cfg(fuse_variant)))
        else $error("shadow not reloaded at turn-on");
    chk_cold_load: assert property (clk_en && uv_ok && !uv_prev_reg |=> // R01
        shadow_config_registers.slots == $past(fuse_cfg(fuse_variant).slots))
        else $error("shadow not loaded on cold start");
    chk_ddr_follow: assert property (ddr_ref_en == reg_en[IDX_BUCK3]) // R07
        else $error("ddr reference differs from buck three");
    chk_slot_off: assert property (state_reg != ST_IDLE && // R14
        shadow_config_registers.slots[IDX_BUCK1] == SLOT_OFF |=> !reg_en[IDX_BUCK1])
        else $error("slot zero regulator enabled");
    chk_untrim_only: assert property (clk_en && !trim_tick_reg && !osc32_raw_tick && // R09
        !uv_ok |=> !timing_trimmed)
        else $error("trimmed clock below threshold");
    chk_tick_glitch: assert property (clk_en && (trim_tick_reg || osc32_raw_tick) |=> // R18
        $stable(sel_trim_reg) || !clk_en)
        else $error("source switched on a tick");
    chk_power_on_reset_out_wait: assert property (clk_en && state_reg == ST_SEQ ##1 // R16
        state_reg == ST_POWER_ON_RESET_OUT |-> !power_on_reset_out [*2])
        else $error("reset output released early");
    chk_sw_tick: assert property (buck_sw_tick |-> $past(osc16_tick)) // R13
        else $error("switching tick without oscillator");
    chk_interval: assert property (state_reg == ST_SEQ && !trim_tick_reg && // R08
        !ivl_done && clk_en |=> $stable(ivl_cnt_reg) || state_reg != ST_SEQ)
        else $error("interval counted off trimmed tick");
endmodule // pss_startup

//--- hw/pss_pkg.sv
package pss_pkg;
    // ==========================================================
    // Regulator indexing and slot codes.
    localparam int N_REG = 10;
    localparam int IDX_BUCK1 = 0;
    localparam int IDX_BUCK3 = 2;
    localparam logic [3:0] SLOT_OFF = 4'h0;

    // ==========================================================
    // Clock rates and derived divisors.
    localparam int OSC16_KHZ = 16000;
    localparam int CLK32_KHZ = 32;
    localparam int BUCK_FREQ_KHZ = 2000;
    localparam int TRIM_DIV = OSC16_KHZ / CLK32_KHZ;
    localparam int SW_DIV = OSC16_KHZ / BUCK_FREQ_KHZ;
    localparam int TICK32_NS = 1000000 / CLK32_KHZ;

    // ==========================================================
    // Times, printed units, and their counts of 32 kHz ticks.
    localparam int SLOT_SHORT_US = 500;
    localparam int SLOT_LONG_US = 2000;
    localparam int POWER_ON_RESET_OUT_DELAY_US = 2000;
    localparam int DEBOUNCE_US = 1000;
    localparam logic [6:0] SLOT_SHORT_TICKS = 7'(SLOT_SHORT_US * 1000 / TICK32_NS);
    localparam logic [6:0] SLOT_LONG_TICKS = 7'(SLOT_LONG_US * 1000 / TICK32_NS);
    localparam logic [6:0] POWER_ON_RESET_OUT_TICKS = 7'(POWER_ON_RESET_OUT_DELAY_US * 1000 / TICK32_NS);
    localparam logic [6:0] DEBOUNCE_TICKS = 7'(DEBOUNCE_US * 1000 / TICK32_NS);

    // ==========================================================
    // Configuration encodings.
    localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h08;
    localparam logic [1:0] FREQ_2MHZ = 2'h1;
    localparam logic [1:0] VARIANT_BLANK = 2'h0;
    localparam logic [1:0] VARIANT_FIRST = 2'h1;
    localparam logic [1:0] VARIANT_SECOND = 2'h2;
    localparam logic [39:0] SLOTS_BLANK = 40'h00_0000_0000;
    localparam logic [39:0] SLOTS_FIRST = 40'h11_9110_0112;
    localparam logic [39:0] SLOTS_SECOND = 40'h06_2322_0201;

    // Shadow configuration image; slots index 0..9 are buck1, buck2, buck3,
    // boost, ldo1..ldo4, three volt rail, card supply.
    typedef struct packed {
        logic [N_REG-1:0][3:0] slots;
        logic seq_slow;
        logic en_edge;
        logic [6:0] bus_addr;
        logic pg_default;
        logic [2:0][1:0] buck_freq;
    } pss_cfg_t;

    // Sequencer states.
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_LOAD = 5'b00010,
        ST_SEQ = 5'b00100,
        ST_POWER_ON_RESET_OUT = 5'b01000,
        ST_DONE = 5'b10000
    } pss_state_t;
endpackage

//--- verif/pss_proc_model.sv
`timescale 1ns/10ps
// ==========================================================
// Oscillators and system processor beside the start-up block.
module pss_proc_model (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Reset output of the block.
    input wire logic power_on_reset_out,
    // Oscillator ticks and processor state.
    output logic osc16_tick,
    output logic osc32_raw_tick,
    output logic proc_running
);
    logic [3:0] phase_reg;

    // One cycle in sixteen carries no tick, so the clock select gets a quiet cycle.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_reg <= 4'h0;
            osc16_tick <= 1'b0;
            osc32_raw_tick <= 1'b0;
        end else begin
            phase_reg <= phase_reg + 4'h1;
            osc16_tick <= (phase_reg != 4'hf);
            osc32_raw_tick <= (phase_reg[1:0] == 2'h0);
        end
    end

    // The processor runs only while its reset input is released.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            proc_running <= 1'b0;
        end else begin
            proc_running <= power_on_reset_out;
        end
    end
endmodule // pss_proc_model

//--- verif/pss_startup_tb.sv
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the start-up sequencer.
module pss_startup_tb import pss_pkg::*;;
    typedef struct packed {
        logic [1:0] variant;
        pss_cfg_t cfg;
    } pss_row_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic uv_ok = 1'b0, all_sleep = 1'b0, all_pfm = 1'b1, low_vin_raw = 1'b0, en_pin = 1'b0;
    logic [1:0] fuse_variant = 2'h0;
    logic shadow_wr = 1'b0;
    pss_cfg_t shadow_wdata = '0;
    pss_cfg_t shadow_config_registers;
    logic [N_REG-1:0] reg_en;
    logic ddr_ref_en, power_on_reset_out, timing_trimmed, timing_tick, buck_sw_tick;
    logic low_input_interrupt, enable_pin_interrupt, osc16_tick, osc32_raw_tick, proc_running;
    logic [3:0] sel_tab [4] = '{4'ha, 4'hc, 4'h9, 4'h0};
    pss_row_t rows [4];
    int checks = 0, n_fail = 0, cycles = 0;

    // Free-running core clock.
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    pss_startup dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .osc16_tick(osc16_tick),
        .osc32_raw_tick(osc32_raw_tick), .uv_ok(uv_ok), .all_sleep(all_sleep),
        .all_pfm(all_pfm), .low_vin_raw(low_vin_raw), .en_pin(en_pin),
        .fuse_variant(fuse_variant), .shadow_wr(shadow_wr), .shadow_wdata(shadow_wdata),
        .shadow_config_registers(shadow_config_registers), .reg_en(reg_en),
        .ddr_ref_en(ddr_ref_en), .power_on_reset_out(power_on_reset_out),
        .timing_trimmed(timing_trimmed), .timing_tick(timing_tick), .buck_sw_tick(buck_sw_tick),
        .low_input_interrupt(low_input_interrupt), .enable_pin_interrupt(enable_pin_interrupt));

    pss_proc_model proc (.core_clk(core_clk), .rst(rst), .power_on_reset_out(power_on_reset_out),
        .osc16_tick(osc16_tick), .osc32_raw_tick(osc32_raw_tick), .proc_running(proc_running));

    // Builds an expected shadow image; everything but slots and interval is common.
    function automatic pss_cfg_t img(input logic [39:0] slots, input logic slow);
        pss_cfg_t c;
        c.slots = slots;
        c.seq_slow = slow;
        c.en_edge = 1'b0;
        c.bus_addr = 7'h08;
        c.pg_default = 1'b1;
        c.buck_freq = {3{FREQ_2MHZ}};
        return c;
    endfunction

    // Condition polled by the bounded wait.
    function automatic logic hit(input int sel);
        case (sel)
            0: return low_input_interrupt === 1'b1;
            1: return reg_en !== '0;
            2: return power_on_reset_out === 1'b1;
            3: return enable_pin_interrupt === 1'b1;
            default: return reg_en === '0;
        endcase
    endfunction

    // Counts cycles until the condition holds, giving up at the limit.
    task automatic wait_for(input int sel, input int lim, output int n);
        n = 0;
        while (!hit(sel) && n < lim) begin
            @(negedge core_clk);
            n++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic results();
        $display("checks %0d, n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            n_fail++;
            $display("mismatch at %0t: run too long", $time);
            results();
        end
    end

    // Main sequence.
    initial begin
        int n, n16, nbk;
        rows[0] = '{2'h0, img(40'h00_0000_0000, 1'b0)};
        rows[1] = '{2'h3, img(40'h00_0000_0000, 1'b0)};
        rows[2] = '{2'h1, img(40'h11_9110_0112, 1'b1)};
        rows[3] = '{2'h2, img(40'h06_2322_0201, 1'b1)};
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        // Clock source in the idle state for each supply and mode case.
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            {uv_ok, all_sleep, all_pfm} <= sel_tab[i][3:1];
            cyc(40);
            chk(timing_trimmed === sel_tab[i][0], "clock source");
        end
        // Each fuse image lands in the shadow on a supply rise.
        foreach (rows[i]) begin
            @(posedge core_clk);
            fuse_variant <= rows[i].variant;
            uv_ok <= 1'b1;
            cyc(4);
            chk(shadow_config_registers === rows[i].cfg, "shadow image");
            @(posedge core_clk);
            uv_ok <= 1'b0;
        end
        // A second reset in mid-run restores the blank image.
        @(posedge core_clk);
        rst <= 1'b1;
        cyc(3);
        chk(shadow_config_registers === rows[0].cfg && reg_en === '0, "reset values");
        @(posedge core_clk);
        rst <= 1'b0;
        fuse_variant <= 2'h1;
        uv_ok <= 1'b1;
        all_pfm <= 1'b0;
        low_vin_raw <= 1'b1;
        // Interrupt debounce stays on the untrimmed clock while the trimmed one is selected.
        wait_for(0, 300, n);
        chk(n >= 110 && n <= 150 && timing_trimmed === 1'b1, "low input debounce");
        n16 = 0;
        nbk = 0;
        repeat (1600) begin
            @(negedge core_clk);
            n16 += int'(osc16_tick);
            nbk += int'(buck_sw_tick);
        end
        chk(nbk * 8 >= n16 - 8 && nbk * 8 <= n16 + 8, "switching tick ratio");
        // Junk in the shadow, then a level turn-on of the first preset.
        @(posedge core_clk);
        all_pfm <= 1'b1;
        shadow_wr <= 1'b1;
        // Junk keeps the level-mode enable so that the level turn-on below still applies.
        shadow_wdata <= img(40'hff_ffff_ffff, 1'b0);
        @(posedge core_clk);
        shadow_wr <= 1'b0;
        en_pin <= 1'b1;
        wait_for(3, 300, n);
        chk(n >= 110 && n <= 150, "enable debounce");
        wait_for(1, 36000, n);
        chk(n >= 33300 && n <= 34400, "first slot time");
        chk(reg_en === 10'h366 && ddr_ref_en === reg_en[IDX_BUCK3], "slot one rails");
        chk(shadow_config_registers === rows[2].cfg, "reload on turn-on");
        chk(power_on_reset_out === 1'b0 && timing_trimmed === 1'b1, "mid sequence");
        @(posedge core_clk);
        uv_ok <= 1'b0;
        wait_for(4, 50, n);
        chk(n < 50 && ddr_ref_en === 1'b0, "turn-off");
        // Blank image: nothing starts and reset is released after the 2.0 ms reset wait.
        @(posedge core_clk);
        fuse_variant <= 2'h0;
        uv_ok <= 1'b1;
        wait_for(2, 36000, n);
        chk(n >= 33300 && n <= 34400 && reg_en === '0, "blank release");
        cyc(2);
        chk(proc_running === 1'b1, "processor released");
        results();
    end
endmodule // pss_startup_tb
